// *** hw/serial_status_pkg.sv ***
// Purpose: shared constants and carriers for the serial port status reporter
// Assumes: four ports, index 0..3 stands for ports 1..4
// Notes:   status area offsets are the printed byte locations
package serial_status_pkg;
    localparam int          NUM_PORTS      = 4;
    // status area byte locations
    localparam logic [9:0]  ERR_STATUS_OFS = 10'h2ea;
    localparam logic [9:0]  IN_LOW_OFS     = 10'h2eb;
    localparam logic [9:0]  IN_HIGH_OFS    = 10'h2ec;
    localparam logic [9:0]  OUT_COUNT_OFS  = 10'h2ed;
    // error status bit positions
    localparam int          ERR_FRAMING    = 7;
    localparam int          ERR_OVERRUN    = 6;
    localparam int          ERR_PARITY     = 5;
    localparam int          ERR_OVERFLOW   = 4;
    localparam int          ERR_ILLEGAL    = 3;
    localparam int          ERR_NOT_READY  = 2;
    localparam int          ERR_BLOCK      = 1;
    localparam int          ERR_COMMAND    = 0;
    localparam logic [7:0]  ERR_RESET      = 8'h00;
    localparam logic [7:0]  ERR_ALL        = 8'hff;
    localparam logic [7:0]  ERR_NO_FRAMING = 8'h7f;
    // monitor mask bit positions
    localparam int          MON_DSR        = 2;
    localparam int          MON_CTS        = 1;
    localparam int          MON_CD         = 0;
    // lines held on: ports 2 and 3 clear-to-send and carrier, port 4 all three
    localparam logic [3:0]  FORCE_CTS_CD   = 4'he;
    localparam logic [3:0]  FORCE_DSR      = 4'h8;
    localparam logic [5:0]  OUT_BUF_MAX    = 6'h20;
    localparam logic [7:0]  BYTE_ZERO      = 8'h00;

    typedef enum logic [1:0] {
        WL_5 = 2'h0,
        WL_6 = 2'h1,
        WL_7 = 2'h2,
        WL_8 = 2'h3
    } word_len_e;

    typedef enum logic [2:0] {
        CMD_STATUS      = 3'h0,
        CMD_START_CIO   = 3'h1,
        CMD_BLOCK_OUT   = 3'h2,
        CMD_CONFIG      = 3'h3,
        CMD_CONFIG_KEEP = 3'h4,
        CMD_CLOSE       = 3'h5
    } cmd_op_e;

    typedef struct packed {
        logic      valid;
        logic      stop_ok;
        word_len_e word_len;
        logic      missed;
        logic      buf_full;
    } rx_event_s;

    typedef struct packed {
        logic valid;
        logic parity_en;
        logic parity_bad;
    } drain_s;

    typedef struct packed {
        logic       valid;
        cmd_op_e    op;
        logic [1:0] port;
        logic       open_input;
        logic       open_output;
        word_len_e  word_len;
        logic       baud_over_300;
        logic [2:0] monitor;
        logic       block_ok;
    } cmd_s;

    typedef struct packed {
        logic [7:0] err;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
    } resp_s;
endpackage

// *** hw/serial_port_status_reporter.sv ***
// Purpose: error status byte, buffer counts and line sense byte for a serial port
// Assumes: events and commands arrive as one-cycle strobes synchronous to mclk_i
// Notes:   one command per cycle; answer one cycle after the command is taken
// Contract
// - Framing flag when stop position lacks stop
// - Module checks framing only for short words
// - Framing flag set on character arrival
// - Inactive status and CMD_CONFIG (not CMD_CONFIG_KEEP) clear framing
// - New I/O start clears other flags
// - Overrun flag on first character after loss
// - Parity flag on drain when checking enabled
// - Overflow flag on arrival at full buffer
// - Refuse illegal short-word concurrent input start
// - Illegal option also sets command error
// - Refusal gives NAK; flags survive next status
// - Refuse on monitored modem line off
// - Block error on bad block from host
// - Command error on unknown or unconfigured command
// - Active status reports input and output counts
// - Reported output count never exceeds 32
// - Sense bits 7,6 give DSR now and history
// - Sense bits 5,4 give CTS now and history
// - Sense bits 3,2 give carrier now and history
// - Sense bit 0 gives receive line level
// - History cleared only by sense status request
// - Ports 2,3,4 report fixed lines as on
`timescale 1ns/10ps
module serial_port_status_reporter
    import serial_status_pkg::*;
(
    input  wire logic                         mclk_i,                  // 25 MHz clock
    input  wire logic                         arst_n_i,                // async reset, low
    input  wire serial_status_pkg::rx_event_s rx_i,                    // character arrival
    input  wire serial_status_pkg::drain_s    drain_i,                 // holding buffer read
    input  wire serial_status_pkg::cmd_s      cmd_i,                   // host command
    input  wire logic [15:0]                  in_count_i,              // input buffer fill
    input  wire logic [5:0]                   out_count_i,             // output buffer fill
    input  wire logic [3:0]                   dsr_i,                   // data set ready, per port
    input  wire logic [3:0]                   cts_i,                   // clear to send, per port
    input  wire logic [3:0]                   carrier_detect_line_i,   // carrier, per port
    input  wire logic [3:0]                   receive_data_line_i,     // rx level, per port
    input  wire logic [9:0]                   rd_addr_i,               // status area address
    output logic [7:0]                        rd_data_o,               // status area byte
    output serial_status_pkg::resp_s          resp_o,                  // last status answer
    output logic                              resp_valid_o,            // answer strobe
    output logic                              ack_o,                   // command accepted
    output logic                              nak_o,                   // command refused
    output logic                              cio_active_o             // concurrent I/O on
);
    import serial_status_pkg::*;

    typedef struct packed {
        logic [7:0] err;
        logic       active;
        logic [1:0] active_port;
        logic       primed;
        logic [3:0] prev_dsr;
        logic [3:0] prev_cts;
        logic [3:0] prev_cd;
        logic [3:0] chg_dsr;
        logic [3:0] chg_cts;
        logic [3:0] chg_cd;
        resp_s      resp;
        logic       resp_valid;
        logic       ack;
        logic       nak;
        logic [7:0] rd_data;
    } state_s;

    state_s     s_reg;
    state_s     s_next;
    logic       rst_meta_reg;
    logic       rst_sync_reg;
    logic       rst_n;
    logic [3:0] dsr_eff;
    logic [3:0] cts_eff;
    logic [3:0] cd_eff;
    logic [3:0] dsr_hist;
    logic [3:0] cts_hist;
    logic [3:0] cd_hist;
    logic [7:0] sense_byte;
    logic [7:0] err_set;
    logic [7:0] err_clr;
    logic [3:0] hist_clr;
    logic [2:0] mon_lines;
    logic       illegal_w;
    logic       not_ready_w;
    logic       refuse;
    logic       port_busy;

    // reset release through two flops
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    // fixed-on lines never move, so their history stays steady
    assign cts_eff = cts_i | FORCE_CTS_CD;
    assign cd_eff  = carrier_detect_line_i | FORCE_CTS_CD;
    assign dsr_eff = dsr_i | FORCE_DSR;

    // history includes a change seen in this very cycle
    assign dsr_hist = s_reg.chg_dsr | ((dsr_eff ^ s_reg.prev_dsr) & {4{s_reg.primed}});
    assign cts_hist = s_reg.chg_cts | ((cts_eff ^ s_reg.prev_cts) & {4{s_reg.primed}});
    assign cd_hist  = s_reg.chg_cd  | ((cd_eff  ^ s_reg.prev_cd)  & {4{s_reg.primed}});

    // steady-on reads both bits set, steady-off reads both clear
    assign sense_byte = {dsr_eff[cmd_i.port], dsr_eff[cmd_i.port] ^ dsr_hist[cmd_i.port],
                         cts_eff[cmd_i.port], cts_eff[cmd_i.port] ^ cts_hist[cmd_i.port],
                         cd_eff[cmd_i.port],  cd_eff[cmd_i.port]  ^ cd_hist[cmd_i.port],
                         1'b0, receive_data_line_i[cmd_i.port]};

    assign mon_lines   = {dsr_eff[cmd_i.port], cts_eff[cmd_i.port], cd_eff[cmd_i.port]};
    assign not_ready_w = |(cmd_i.monitor & ~mon_lines);
    assign illegal_w   = cmd_i.open_input && (cmd_i.word_len != WL_8) &&
                         (cmd_i.open_output || cmd_i.baud_over_300);
    assign port_busy   = s_reg.active && (cmd_i.port != s_reg.active_port);

    always_comb begin
        s_next            = s_reg;
        s_next.ack        = 1'b0;
        s_next.nak        = 1'b0;
        s_next.resp_valid = 1'b0;
        err_set           = ERR_RESET;
        err_clr           = ERR_RESET;
        hist_clr          = 4'h0;
        refuse            = 1'b0;

        if (rx_i.valid && (rx_i.word_len != WL_8) && !rx_i.stop_ok) begin
            err_set[ERR_FRAMING] = 1'b1;
        end
        if (rx_i.valid && rx_i.missed) begin
            err_set[ERR_OVERRUN] = 1'b1;
        end
        if (rx_i.valid && rx_i.buf_full) begin
            err_set[ERR_OVERFLOW] = 1'b1;
        end
        if (drain_i.valid && drain_i.parity_en && drain_i.parity_bad) begin
            err_set[ERR_PARITY] = 1'b1;
        end

        if (cmd_i.valid) begin
            unique case (cmd_i.op)
                CMD_STATUS: begin
                    if (port_busy) begin
                        refuse                 = 1'b1;
                        err_set[ERR_COMMAND]   = 1'b1;
                    end else begin
                        // answer first, then clear: the flags of a refusal stay readable
                        s_next.resp.err        = s_reg.err;
                        s_next.resp_valid      = 1'b1;
                        if (s_reg.active) begin
                            s_next.resp.b1     = in_count_i[7:0];
                            s_next.resp.b2     = in_count_i[15:8];
                            s_next.resp.b3     = (out_count_i > OUT_BUF_MAX) ?
                                                 {2'h0, OUT_BUF_MAX} :
                                                 {2'h0, out_count_i};
                            err_clr            = ERR_NO_FRAMING;
                        end else begin
                            s_next.resp.b1     = sense_byte;
                            s_next.resp.b2     = BYTE_ZERO;
                            s_next.resp.b3     = BYTE_ZERO;
                            err_clr            = ERR_ALL;
                            hist_clr[cmd_i.port] = 1'b1;
                        end
                    end
                end
                CMD_START_CIO: begin
                    err_clr = ERR_NO_FRAMING;
                    if (s_reg.active) begin
                        refuse               = 1'b1;
                        err_set[ERR_COMMAND] = 1'b1;
                    end else if (illegal_w) begin
                        refuse               = 1'b1;
                        err_set[ERR_ILLEGAL] = 1'b1;
                        err_set[ERR_COMMAND] = 1'b1;
                    end else if (not_ready_w) begin
                        refuse                 = 1'b1;
                        err_set[ERR_NOT_READY] = 1'b1;
                    end else begin
                        s_next.active      = 1'b1;
                        s_next.active_port = cmd_i.port;
                    end
                end
                CMD_BLOCK_OUT: begin
                    err_clr = ERR_NO_FRAMING;
                    if (port_busy) begin
                        refuse               = 1'b1;
                        err_set[ERR_COMMAND] = 1'b1;
                    end else if (not_ready_w) begin
                        refuse                 = 1'b1;
                        err_set[ERR_NOT_READY] = 1'b1;
                    end else if (!cmd_i.block_ok) begin
                        refuse             = 1'b1;
                        err_set[ERR_BLOCK] = 1'b1;
                    end
                end
                CMD_CONFIG: begin
                    err_clr[ERR_FRAMING] = 1'b1;
                end
                CMD_CONFIG_KEEP: begin
                end
                CMD_CLOSE: begin
                    if (!s_reg.active) begin
                        err_clr[ERR_FRAMING] = 1'b1;
                    end
                    s_next.active = 1'b0;
                end
                default: begin
                    refuse               = 1'b1;
                    err_set[ERR_COMMAND] = 1'b1;
                end
            endcase
            s_next.nak = refuse;
            s_next.ack = !refuse;
        end

        // a set in the same cycle as a clear wins
        s_next.err = (s_reg.err & ~err_clr) | err_set;

        s_next.primed   = 1'b1;
        s_next.prev_dsr = dsr_eff;
        s_next.prev_cts = cts_eff;
        s_next.prev_cd  = cd_eff;
        s_next.chg_dsr  = (s_reg.chg_dsr & ~hist_clr) | (dsr_hist & ~s_reg.chg_dsr & ~hist_clr)
                          | ((dsr_eff ^ s_reg.prev_dsr) & {4{s_reg.primed}});
        s_next.chg_cts  = (cts_hist & ~hist_clr)
                          | ((cts_eff ^ s_reg.prev_cts) & {4{s_reg.primed}});
        s_next.chg_cd   = (cd_hist & ~hist_clr)
                          | ((cd_eff ^ s_reg.prev_cd) & {4{s_reg.primed}});

        unique case (rd_addr_i)
            ERR_STATUS_OFS: s_next.rd_data = s_reg.resp.err;
            IN_LOW_OFS:     s_next.rd_data = s_reg.resp.b1;
            IN_HIGH_OFS:    s_next.rd_data = s_reg.resp.b2;
            OUT_COUNT_OFS:  s_next.rd_data = s_reg.resp.b3;
            default:        s_next.rd_data = BYTE_ZERO;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rd_data_o    = s_reg.rd_data;
    assign resp_o       = s_reg.resp;
    assign resp_valid_o = s_reg.resp_valid;
    assign ack_o        = s_reg.ack;
    assign nak_o        = s_reg.nak;
    assign cio_active_o = s_reg.active;

    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);

    logic sense_req;
    logic act_req;
    logic [1:0] req_port;
    assign sense_req = cmd_i.valid && (cmd_i.op == CMD_STATUS) && !s_reg.active;
    assign act_req   = cmd_i.valid && (cmd_i.op == CMD_STATUS) && s_reg.active && !port_busy;
    assign req_port  = cmd_i.port;

    sequence illegal_start_s;
        cmd_i.valid && (cmd_i.op == CMD_START_CIO) && !s_reg.active && illegal_w;
    endsequence
    sequence quiet_status_s;
        sense_req && !(cmd_i.valid && (cmd_i.op == CMD_START_CIO));
    endsequence

    framing_set_a: assert property (
        rx_i.valid && (rx_i.word_len != WL_8) && !rx_i.stop_ok
        |=> s_reg.err[ERR_FRAMING])
        else $error("framing flag not set on bad stop");
    framing_host_a: assert property (
        !s_reg.err[ERR_FRAMING] && !(rx_i.valid && rx_i.word_len != WL_8 && !rx_i.stop_ok)
        |=> !s_reg.err[ERR_FRAMING])
        else $error("framing flag set without a short-word fault");
    framing_clear_a: assert property (
        sense_req && !rx_i.valid |=> !s_reg.err[ERR_FRAMING])
        else $error("framing flag survived inactive status");
    start_clear_a: assert property (
        cmd_i.valid && (cmd_i.op == CMD_START_CIO) && !s_reg.active && !illegal_w
        && !not_ready_w && !rx_i.valid && !drain_i.valid
        |=> (s_reg.err[6:0] == 7'h00) && s_reg.active && ack_o)
        else $error("accepted start left stale flags");
    overrun_set_a: assert property (
        rx_i.valid && rx_i.missed |=> s_reg.err[ERR_OVERRUN])
        else $error("overrun flag missing");
    parity_gate_a: assert property (
        !s_reg.err[ERR_PARITY] && !(drain_i.valid && drain_i.parity_en) |=> !s_reg.err[ERR_PARITY])
        else $error("parity flag set with checking off");
    overflow_set_a: assert property (
        rx_i.valid && rx_i.buf_full |=> s_reg.err[ERR_OVERFLOW])
        else $error("overflow flag missing");
    illegal_seen_a: assert property (
        illegal_start_s ##1 !cmd_i.valid ##1 quiet_status_s
        |=> resp_valid_o && resp_o.err[ERR_ILLEGAL] && resp_o.err[ERR_COMMAND] && !s_reg.active)
        else $error("illegal start not reported");
    illegal_cmd_a: assert property (
        s_reg.err[ERR_ILLEGAL] && !$past(s_reg.err[ERR_ILLEGAL]) |-> s_reg.err[ERR_COMMAND])
        else $error("illegal option without command error");
    refuse_nak_a: assert property (
        illegal_start_s |=> nak_o && !ack_o ##1 (!nak_o || $past(cmd_i.valid)))
        else $error("refusal not answered by one nak");
    not_ready_a: assert property (
        cmd_i.valid && (cmd_i.op == CMD_START_CIO) && !s_reg.active && !illegal_w && not_ready_w
        |=> nak_o && s_reg.err[ERR_NOT_READY] && !s_reg.active)
        else $error("not-ready start was not refused");
    block_err_a: assert property (
        cmd_i.valid && (cmd_i.op == CMD_BLOCK_OUT) && !port_busy && !not_ready_w && !cmd_i.block_ok
        |=> nak_o && s_reg.err[ERR_BLOCK])
        else $error("bad block not flagged");
    unknown_cmd_a: assert property (
        cmd_i.valid && (cmd_i.op > CMD_CLOSE) |=> nak_o && s_reg.err[ERR_COMMAND])
        else $error("unknown command accepted");
    input_counts_a: assert property (
        act_req |=> resp_valid_o && (resp_o.b1 == $past(in_count_i[7:0]))
        && (resp_o.b2 == $past(in_count_i[15:8])))
        else $error("input count misreported");
    out_limit_a: assert property (
        resp_o.b3 <= {2'h0, OUT_BUF_MAX})
        else $error("output count above limit");
    dsr_now_a: assert property (
        sense_req |=> resp_o.b1[7] == $past(dsr_eff[req_port]))
        else $error("sense dsr level wrong");
    cts_now_a: assert property (
        sense_req |=> resp_o.b1[5] == $past(cts_eff[req_port]))
        else $error("sense cts level wrong");
    rcv_level_a: assert property (
        sense_req |=> (resp_o.b1[0] == $past(receive_data_line_i[req_port])) && !resp_o.b1[1])
        else $error("sense receive level wrong");
    hist_reset_a: assert property (
        sense_req && $stable(dsr_eff) && $stable(cts_eff) && $stable(cd_eff)
        ##1 $stable(dsr_eff) && $stable(cts_eff) && $stable(cd_eff) && $stable(req_port)
        ##1 sense_req && $stable(dsr_eff) && $stable(cts_eff) && $stable(cd_eff)
        && $stable(req_port)
        |=> (resp_o.b1[7] == resp_o.b1[6]) && (resp_o.b1[5] == resp_o.b1[4])
        && (resp_o.b1[3] == resp_o.b1[2]))
        else $error("history not cleared by sense status");
    forced_on_a: assert property (
        sense_req && (req_port != 2'h0) |=> (resp_o.b1[5:2] == 4'hf)
        && (($past(req_port) != 2'h3) || (resp_o.b1[7:6] == 2'h3)))
        else $error("fixed lines not reported steady on");
endmodule

// *** testbench/serial_host_model.sv ***
// Purpose: host side issuing commands to the status reporter
// Assumes: one command at a time, answer one cycle after it is taken
// Notes:   8-bit framing is judged on this side, so it never asks for it
`timescale 1ns/10ps
module serial_host_model
    import serial_status_pkg::*;
(
    input  wire logic                     mclk_i, // clock
    output serial_status_pkg::cmd_s       cmd_o,  // command to block
    input  wire logic                     ack_i,  // accepted
    input  wire logic                     nak_i,  // refused
    input  wire serial_status_pkg::resp_s resp_i  // status answer
);
    initial cmd_o = '0;
    // bad picks short words with output open and a spoilt data block
    task automatic send(input cmd_op_e op, input logic [1:0] port, input logic [2:0] mon,
                        input logic bad, output logic ak, output logic nk, output resp_s r);
        @(posedge mclk_i);
        cmd_o <= '{1'b1, op, port, 1'b1, bad, bad ? WL_7 : WL_8, 1'b0, mon, ~bad};
        @(posedge mclk_i);
        cmd_o.valid <= 1'b0;
        #1;
        ak = ack_i;
        nk = nak_i;
        r = resp_i;
    endtask
endmodule

// *** testbench/serial_port_status_reporter_tb_top.sv ***
// Purpose: self-checking bench for the serial port status reporter
// Assumes: host model issues commands, bench drives line and buffer events
// Notes:   ports are numbered from 0 at the pins
`timescale 1ns/10ps
module serial_port_status_reporter_tb_top;
    import serial_status_pkg::*;
    logic mclk_i = 0, arst_n_i = 0, ak, nk, rv, act;
    rx_event_s rx = '0;
    drain_s dr = '0;
    cmd_s cmd;
    resp_s rs, r;
    logic [15:0] inc = 16'h0123;
    logic [5:0] outc = 6'h3f;
    logic [3:0] dsr = 0, cts = 0, cd = 0, rxl = 4'h7;
    logic [9:0] ra = ERR_STATUS_OFS;
    logic [7:0] rd;
    int fail_count = 0, n_compared = 0;
    serial_port_status_reporter u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .rx_i(rx),
        .drain_i(dr), .cmd_i(cmd), .in_count_i(inc), .out_count_i(outc), .dsr_i(dsr),
        .cts_i(cts), .carrier_detect_line_i(cd), .receive_data_line_i(rxl), .rd_addr_i(ra),
        .rd_data_o(rd), .resp_o(rs), .resp_valid_o(rv), .ack_o(ak), .nak_o(nk),
        .cio_active_o(act));
    serial_host_model u_host (.mclk_i(mclk_i), .cmd_o(cmd), .ack_i(ak), .nak_i(nk),
        .resp_i(rs));
    initial forever #20 mclk_i = ~mclk_i;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cmdx(input cmd_op_e op, input logic [1:0] p, input logic [2:0] m,
                        input logic bad, input logic [1:0] exp_an);
        logic a, n;
        u_host.send(op, p, m, bad, a, n, r);
        chk("ack_nak", {a, n}, exp_an);
        chk("resp_valid", rv, (op == CMD_STATUS) && (exp_an == 2'h2));
    endtask
    task automatic ev(input rx_event_s e, input drain_s d);
        @(posedge mclk_i);
        rx <= e;
        dr <= d;
        @(posedge mclk_i);
        rx.valid <= 1'b0;
        dr.valid <= 1'b0;
    endtask
    task automatic s_sense();
        cmdx(CMD_STATUS, 2'h0, 3'h0, 1'b0, 2'h2);
        chk("sense_idle", r.b1, 8'h01);
        @(posedge mclk_i);
        dsr <= 4'h1;
        cmdx(CMD_STATUS, 2'h0, 3'h0, 1'b0, 2'h2);
        chk("sense_dsr_new", r.b1, 8'h81);
        @(posedge mclk_i);
        cts <= 4'h1;
        cd <= 4'h1;
        cmdx(CMD_STATUS, 2'h0, 3'h0, 1'b0, 2'h2);
        chk("sense_cts_cd", r.b1, 8'he9);
        cmdx(CMD_STATUS, 2'h0, 3'h0, 1'b0, 2'h2);
        chk("sense_steady", r.b1, 8'hfd);
        cmdx(CMD_STATUS, 2'h3, 3'h0, 1'b0, 2'h2);
        chk("sense_port4", r.b1, 8'hfc);
    endtask
    task automatic s_refuse();
        cmdx(CMD_START_CIO, 2'h0, 3'h0, 1'b1, 2'h1);
        cmdx(CMD_STATUS, 2'h0, 3'h0, 1'b0, 2'h2);
        chk("illegal_err", r.err, 8'h09);
        @(posedge mclk_i);
        #1;
        chk("rd_err", rd, 8'h09);
        cmdx(CMD_START_CIO, 2'h1, 3'h4, 1'b0, 2'h1);
        cmdx(CMD_STATUS, 2'h1, 3'h0, 1'b0, 2'h2);
        chk("notready_err", r.err, 8'h04);
        cmdx(cmd_op_e'(3'h6), 2'h0, 3'h0, 1'b0, 2'h1);
        cmdx(CMD_STATUS, 2'h0, 3'h0, 1'b0, 2'h2);
        chk("unknown_err", r.err, 8'h01);
        cmdx(CMD_BLOCK_OUT, 2'h0, 3'h0, 1'b1, 2'h1);
        cmdx(CMD_STATUS, 2'h0, 3'h0, 1'b0, 2'h2);
        chk("block_err", r.err, 8'h02);
        cmdx(CMD_BLOCK_OUT, 2'h0, 3'h4, 1'b0, 2'h2);
        cmdx(CMD_STATUS, 2'h0, 3'h0, 1'b0, 2'h2);
        chk("block_ok", r.err, 8'h00);
    endtask
    task automatic s_frame();
        ev('{1'b1, 1'b0, WL_7, 1'b0, 1'b0}, '0);
        cmdx(CMD_STATUS, 2'h0, 3'h0, 1'b0, 2'h2);
        chk("frame_short", r.err, 8'h80);
        cmdx(CMD_STATUS, 2'h0, 3'h0, 1'b0, 2'h2);
        chk("frame_cleared", r.err, 8'h00);
        ev('{1'b1, 1'b0, WL_8, 1'b0, 1'b0}, '0);
        cmdx(CMD_STATUS, 2'h0, 3'h0, 1'b0, 2'h2);
        chk("frame_long", r.err, 8'h00);
        ev('{1'b1, 1'b0, WL_5, 1'b0, 1'b0}, '0);
        cmdx(CMD_CONFIG_KEEP, 2'h0, 3'h0, 1'b0, 2'h2);
        cmdx(CMD_STATUS, 2'h0, 3'h0, 1'b0, 2'h2);
        chk("frame_keep", r.err, 8'h80);
        ev('{1'b1, 1'b0, WL_6, 1'b0, 1'b0}, '0);
        cmdx(CMD_CONFIG, 2'h0, 3'h0, 1'b0, 2'h2);
        cmdx(CMD_STATUS, 2'h0, 3'h0, 1'b0, 2'h2);
        chk("frame_config", r.err, 8'h00);
    endtask
    task automatic s_cio();
        cmdx(CMD_START_CIO, 2'h0, 3'h7, 1'b0, 2'h2);
        chk("cio_on", act, 1'b1);
        ev('{1'b1, 1'b1, WL_8, 1'b1, 1'b1}, '{1'b1, 1'b1, 1'b1});
        ev('0, '{1'b1, 1'b0, 1'b1});
        cmdx(CMD_STATUS, 2'h1, 3'h0, 1'b0, 2'h1);
        cmdx(CMD_STATUS, 2'h0, 3'h0, 1'b0, 2'h2);
        chk("cio_resp", r, 32'h71230120);
        @(posedge mclk_i);
        ra <= IN_HIGH_OFS;
        @(posedge mclk_i);
        #1;
        chk("rd_high", rd, 8'h01);
        cmdx(CMD_STATUS, 2'h0, 3'h0, 1'b0, 2'h2);
        chk("cio_clear", r.err, 8'h00);
        cmdx(CMD_CLOSE, 2'h0, 3'h0, 1'b0, 2'h2);
        chk("cio_off", act, 1'b0);
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        s_sense();
        s_refuse();
        s_frame();
        s_cio();
        give_verdict();
    end
    initial begin
        #100us;
        fail_count++;
        give_verdict();
    end
endmodule
